// ===== rtl/translation_buffer_fault_unit.sv
// Translation buffer, memory fault classifier and context swap unit
// Behaviour
// (R1) Cache successful translations with page state to skip table reads.
// (R2) Context swap loads new tag; tagless mode drops non-global entries.
// (R3) Firmware issues single-entry invalidate after changing a valid entry.
// (R4) Invalidate-all clears everything; invalidate-process clears non-global entries.
// (R5) An entry with valid bit clear is never loaded.
// (R6) Tags are local; no coherency with other processors.
// (R7) Three tag bits: five process tags, one global, one invalid code.
// (R8) Fault code: 0 not valid, 1 access, 2 read, 3 execute, 4 write.
// (R9) Invalid entry at any table level gives translation-not-valid.
// (R10) User-segment protection forbidding access in current mode gives access violation.
// (R11) Invalid upper-level entry with kernel read clear gives access violation.
// (R12) Kernel direct segment touched in user mode gives access violation.
// (R13) Data read on page with fault-on-read set gives read fault.
// (R14) Fetch on page with fault-on-execute set gives execute fault.
// (R15) Store on page with fault-on-write set gives write fault.
// (R16) Block: kernel sp 00, user sp 08, table base 16, tag 24, counters 32.
// (R17) Context swap saves outgoing context and loads the incoming one.
// (R18) Software aligns context blocks to eight, ideally 64 bytes.
// (R19) Dedicated access to user sp, cycle counter and unique value.
// (R20) Mode 0 is kernel, 1 is user for per-mode enables.
// (R21) Global entries match any tag; others only the current tag.
module translation_buffer_fault_unit (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O
);
  localparam int NE = tbf_pkg::TB_ENTRIES;

  logic ctrl_asn_off;
  logic [31:0] va, pte1, pte2, pte3, phys, kernel_stack_pointer, user_stack_pointer, page_table_base, address_space_tag, process_cycle_counter, uniq_val;
  logic [1:0] acc;
  logic mode, hit_flag, fault_flag, loaded, asn_bad;
  logic [2:0] fault_code, cur_blk, rr, victim;
  logic [63:0] pcb_mem [tbf_pkg::PCB_QUADS];
  logic [NE-1:0] slot_hit, slot_valid, slot_global;
  logic [31:0] slot_pte [NE];
  logic [31:0] hit_pte;

  // ****************************************
  // Bus decode
  // ****************************************
  wire req = CYC_I & STB_I & ~ACK_O;
  wire wr = req & WE_I;
  wire [11:0] adr = {ADR_I[11:2], 2'h0};
  // Blocks sit 64 bytes apart, so every block is suitably aligned
  wire in_pcb = adr[11:9] == tbf_pkg::PCB_WIN; // R18
  wire [5:0] pidx = adr[8:3];
  wire pcb_hi = adr[2];
  wire pcb_wr = wr & in_pcb;
  wire cmd_go = wr & (adr == tbf_pkg::REG_CMD) & SEL_I[0];
  wire [3:0] cmd = DAT_I[3:0];
  wire [2:0] new_blk = DAT_I[10:8];
  wire do_tbia = cmd_go & (cmd == tbf_pkg::CMD_TBIA);
  wire do_tbiap = cmd_go & (cmd == tbf_pkg::CMD_TBIAP);
  wire do_tbis = cmd_go & (cmd == tbf_pkg::CMD_TBIS);
  wire do_lookup = cmd_go & (cmd == tbf_pkg::CMD_LOOKUP);
  wire do_fill = cmd_go & (cmd == tbf_pkg::CMD_FILL);
  wire do_swap = cmd_go & (cmd == tbf_pkg::CMD_SWAP);

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  // ****************************************
  // Fault classification
  // ****************************************
  // Upper-level entry: {fault, code}
  function automatic logic [3:0] upper_res(input logic [31:0] p);
    if (p[tbf_pkg::PTE_V]) begin
      upper_res = 4'h0;
    end else if (!p[tbf_pkg::PTE_KRE]) begin
      upper_res = {1'b1, tbf_pkg::FC_ACV}; // R11
    end else begin
      upper_res = {1'b1, tbf_pkg::FC_TNV}; // R9
    end
  endfunction

  // Leaf entry: protection is checked before validity, fetches count as reads
  function automatic logic [3:0] leaf_res(input logic [31:0] p, input logic [1:0] a,
                                          input logic m);
    logic w;
    logic deny;
    w = a == tbf_pkg::ACC_WRITE;
    if (m == tbf_pkg::MODE_USER) begin
      deny = w ? !p[tbf_pkg::PTE_UWE] : !p[tbf_pkg::PTE_URE]; // R20
    end else begin
      deny = w ? !p[tbf_pkg::PTE_KWE] : !p[tbf_pkg::PTE_KRE]; // R20
    end
    if (deny) begin
      leaf_res = {1'b1, tbf_pkg::FC_ACV}; // R10
    end else if (!p[tbf_pkg::PTE_V]) begin
      leaf_res = {1'b1, tbf_pkg::FC_TNV}; // R9
    end else if (w && p[tbf_pkg::PTE_FAULT_WRITE]) begin
      leaf_res = {1'b1, tbf_pkg::FC_FOW}; // R15
    end else if (a == tbf_pkg::ACC_READ && p[tbf_pkg::PTE_FAULT_READ]) begin
      leaf_res = {1'b1, tbf_pkg::FC_FOR}; // R13
    end else if (a == tbf_pkg::ACC_EXEC && p[tbf_pkg::PTE_FAULT_EXEC]) begin
      leaf_res = {1'b1, tbf_pkg::FC_FOE}; // R14
    end else begin
      leaf_res = 4'h0;
    end
  endfunction

  wire kseg = va[31:30] == tbf_pkg::KSEG_SEL;
  wire user = mode == tbf_pkg::MODE_USER;
  wire [3:0] kseg_res = user ? {1'b1, tbf_pkg::FC_ACV} : 4'h0; // R12
  wire [3:0] l1_res = upper_res(pte1);
  wire [3:0] l2_res = upper_res(pte2);
  wire [3:0] l3_res = leaf_res(pte3, acc, mode);
  wire [3:0] walk_res = kseg ? kseg_res : l1_res[3] ? l1_res : l2_res[3] ? l2_res : l3_res;
  wire [3:0] hit_res = kseg ? kseg_res : leaf_res(hit_pte, acc, mode);
  wire any_hit = |slot_hit;
  // Only a clean walk through a valid leaf is cached
  wire fill_ok = !kseg && !walk_res[3] && pte3[tbf_pkg::PTE_V]; // R5
  wire [31:0] kseg_pa = {2'h0, va[29:0]};
  wire [31:0] hit_pa = {3'h0, hit_pte[31:tbf_pkg::PTE_PFN_LSB], va[12:0]};
  wire [31:0] walk_pa = {3'h0, pte3[31:tbf_pkg::PTE_PFN_LSB], va[12:0]};

  // ****************************************
  // Translation buffer
  // ****************************************
  // Tags belong to this processor only; nothing snoops other processors
  wire asn_ok = address_space_tag < {29'h0, tbf_pkg::ASN_COUNT}; // R6
  wire [2:0] cur_tag = asn_ok ? address_space_tag[2:0] : tbf_pkg::TAG_DEFAULT; // R7
  wire [2:0] fill_tag = pte3[tbf_pkg::PTE_GLOBAL] ? tbf_pkg::TAG_GLOBAL : cur_tag; // R7
  wire [31:0] in_ksp = pcb_mem[{new_blk, tbf_pkg::PCB_KSP}][31:0];
  wire [31:0] in_usp = pcb_mem[{new_blk, tbf_pkg::PCB_USP}][31:0];
  wire [31:0] in_page_table_base = pcb_mem[{new_blk, tbf_pkg::PCB_PAGE_TABLE_BASE}][31:0];
  wire [31:0] in_asn = pcb_mem[{new_blk, tbf_pkg::PCB_ASN}][31:0];
  wire [63:0] in_cnt = pcb_mem[{new_blk, tbf_pkg::PCB_PCC}];
  wire in_asn_bad = in_asn >= {29'h0, tbf_pkg::ASN_COUNT};
  // Without usable tags a swap must drop all process-private entries
  wire swap_flush = do_swap & (ctrl_asn_off | in_asn_bad); // R2
  wire inv_proc = do_tbiap | swap_flush; // R4

  always_comb begin
    hit_pte = tbf_pkg::RST_WORD;
    victim = rr;
    for (int i = 0; i < NE; i++) begin
      if (slot_hit[i]) begin
        hit_pte = hit_pte | slot_pte[i];
        victim = 3'(i);
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++) begin : g_slot
      tb_slot u_slot (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .load(do_fill && fill_ok && victim == 3'(gi)), // R1
        .inv_all(do_tbia),
        .inv_proc(inv_proc),
        .inv_one(do_tbis), // R3
        .fill_vpn(va[31:tbf_pkg::PAGE_BITS]),
        .fill_tag(fill_tag),
        .fill_pte(pte3),
        .cur_tag(cur_tag),
        .probe_vpn(va[31:tbf_pkg::PAGE_BITS]),
        .hit(slot_hit[gi]),
        .is_valid(slot_valid[gi]),
        .is_global(slot_global[gi]),
        .pte(slot_pte[gi])
      );
    end
  endgenerate

  // Replacement rotates only when a new page is brought in
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rr <= 3'h0;
    end else if (do_fill && fill_ok && !any_hit) begin
      rr <= rr + 3'h1;
    end
  end

  // ****************************************
  // Command results
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      hit_flag <= 1'b0;
      fault_flag <= 1'b0;
      loaded <= 1'b0;
      fault_code <= tbf_pkg::FC_TNV;
      phys <= tbf_pkg::RST_WORD;
    end else if (do_lookup) begin
      hit_flag <= kseg | any_hit;
      fault_flag <= (kseg | any_hit) & hit_res[3];
      loaded <= 1'b0;
      fault_code <= hit_res[2:0]; // R8
      phys <= kseg ? kseg_pa : hit_pa;
    end else if (do_fill) begin
      hit_flag <= kseg;
      fault_flag <= walk_res[3];
      loaded <= fill_ok;
      fault_code <= walk_res[2:0]; // R8
      phys <= kseg ? kseg_pa : walk_pa;
    end
  end

  // ****************************************
  // Software registers and process context
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_asn_off <= 1'b0;
      va <= tbf_pkg::RST_WORD;
      acc <= tbf_pkg::ACC_READ;
      mode <= tbf_pkg::MODE_KERNEL;
      pte1 <= tbf_pkg::RST_WORD;
      pte2 <= tbf_pkg::RST_WORD;
      pte3 <= tbf_pkg::RST_WORD;
      kernel_stack_pointer <= tbf_pkg::RST_WORD;
      user_stack_pointer <= tbf_pkg::RST_WORD;
      page_table_base <= tbf_pkg::RST_WORD;
      address_space_tag <= tbf_pkg::RST_WORD;
      process_cycle_counter <= tbf_pkg::RST_WORD;
      uniq_val <= tbf_pkg::RST_WORD;
      cur_blk <= 3'h0;
      asn_bad <= 1'b0;
    end else if (do_swap) begin
      kernel_stack_pointer <= in_ksp; // R17
      user_stack_pointer <= in_usp;
      page_table_base <= in_page_table_base;
      address_space_tag <= in_asn; // R2
      asn_bad <= in_asn_bad;
      process_cycle_counter <= in_cnt[31:0];
      uniq_val <= in_cnt[63:32];
      cur_blk <= new_blk;
    end else begin
      process_cycle_counter <= process_cycle_counter + 32'h1;
      if (wr && adr == tbf_pkg::REG_CTRL && SEL_I[0]) ctrl_asn_off <= DAT_I[0];
      if (wr && adr == tbf_pkg::REG_VA) va <= wmerge(va, DAT_I, SEL_I);
      if (wr && adr == tbf_pkg::REG_ACCESS && SEL_I[0]) begin
        acc <= DAT_I[1:0];
        mode <= DAT_I[2];
      end
      if (wr && adr == tbf_pkg::REG_PTE1) pte1 <= wmerge(pte1, DAT_I, SEL_I);
      if (wr && adr == tbf_pkg::REG_PTE2) pte2 <= wmerge(pte2, DAT_I, SEL_I);
      if (wr && adr == tbf_pkg::REG_PTE3) pte3 <= wmerge(pte3, DAT_I, SEL_I);
      if (wr && adr == tbf_pkg::REG_KSP) kernel_stack_pointer <= wmerge(kernel_stack_pointer, DAT_I, SEL_I);
      if (wr && adr == tbf_pkg::REG_USP) user_stack_pointer <= wmerge(user_stack_pointer, DAT_I, SEL_I); // R19
      if (wr && adr == tbf_pkg::REG_UNIQUE) uniq_val <= wmerge(uniq_val, DAT_I, SEL_I); // R19
    end
  end

  // Outgoing context goes to its block in the same edge the new one is read
  always_ff @(posedge REF_CLK) begin
    if (do_swap) begin
      pcb_mem[{cur_blk, tbf_pkg::PCB_KSP}] <= {32'h0, kernel_stack_pointer}; // R16
      pcb_mem[{cur_blk, tbf_pkg::PCB_USP}] <= {32'h0, user_stack_pointer}; // R16
      pcb_mem[{cur_blk, tbf_pkg::PCB_PAGE_TABLE_BASE}] <= {32'h0, page_table_base}; // R16
      pcb_mem[{cur_blk, tbf_pkg::PCB_ASN}] <= {32'h0, address_space_tag}; // R16
      pcb_mem[{cur_blk, tbf_pkg::PCB_PCC}] <= {uniq_val, process_cycle_counter}; // R17
    end else if (pcb_wr && pcb_hi) begin
      pcb_mem[pidx][63:32] <= wmerge(pcb_mem[pidx][63:32], DAT_I, SEL_I);
    end else if (pcb_wr) begin
      pcb_mem[pidx][31:0] <= wmerge(pcb_mem[pidx][31:0], DAT_I, SEL_I);
    end
  end

  // ****************************************
  // Read path and acknowledge
  // ****************************************
  wire [31:0] status_word = {28'h0, asn_bad, loaded, fault_flag, hit_flag};
  wire [63:0] pcb_q = pcb_mem[pidx];
  wire [31:0] rd_word =
    in_pcb ? (pcb_hi ? pcb_q[63:32] : pcb_q[31:0]) :
    adr == tbf_pkg::REG_CTRL ? {31'h0, ctrl_asn_off} :
    adr == tbf_pkg::REG_VA ? va :
    adr == tbf_pkg::REG_ACCESS ? {29'h0, mode, acc} :
    adr == tbf_pkg::REG_PTE1 ? pte1 :
    adr == tbf_pkg::REG_PTE2 ? pte2 :
    adr == tbf_pkg::REG_PTE3 ? pte3 :
    adr == tbf_pkg::REG_STATUS ? status_word :
    adr == tbf_pkg::REG_FAULT ? {29'h0, fault_code} :
    adr == tbf_pkg::REG_PHYS ? phys :
    adr == tbf_pkg::REG_KSP ? kernel_stack_pointer :
    adr == tbf_pkg::REG_USP ? user_stack_pointer :
    adr == tbf_pkg::REG_PAGE_TABLE_BASE ? page_table_base :
    adr == tbf_pkg::REG_ASN ? address_space_tag :
    adr == tbf_pkg::REG_PCC ? process_cycle_counter :
    adr == tbf_pkg::REG_UNIQUE ? uniq_val :
    adr == tbf_pkg::REG_BLOCK ? {29'h0, cur_blk} : tbf_pkg::RST_WORD;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
      DAT_O <= tbf_pkg::RST_WORD;
    end else begin
      ACK_O <= req;
      DAT_O <= (req && !WE_I) ? rd_word : tbf_pkg::RST_WORD;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_bus_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_clean_fill;
    do_fill && fill_ok;
  endsequence

  chk_ack_single: assert property (s_bus_req |=> ACK_O ##1 !ACK_O)
    else $error("ack not a single cycle");
  chk_tbia_all: assert property (do_tbia |=> slot_valid == '0) // R4
    else $error("entries survive invalidate-all");
  chk_tbiap_keep: assert property (do_tbiap |=> (slot_valid & ~slot_global) == '0) // R4
    else $error("private entry survives invalidate-process");
  chk_no_invalid_fill: assert property ( // R5
    do_fill && !pte3[tbf_pkg::PTE_V] |=> slot_valid == $past(slot_valid))
    else $error("invalid entry was cached");
  // The bus cannot change the address in the ack cycle, so the new entry must hit then
  chk_fill_then_hit: assert property (s_clean_fill |=> any_hit) // R1
    else $error("filled page misses");
  chk_kseg_user: assert property ( // R12
    (do_lookup || do_fill) && kseg && user |=> fault_flag && fault_code == tbf_pkg::FC_ACV)
    else $error("user kernel-segment access not refused");
  chk_upper_kre: assert property ( // R11
    do_fill && !kseg && !pte1[tbf_pkg::PTE_V] && !pte1[tbf_pkg::PTE_KRE]
    |=> fault_code == tbf_pkg::FC_ACV && !loaded)
    else $error("upper entry without kernel read not refused");
  chk_swap_load: assert property ( // R17
    do_swap |=> kernel_stack_pointer == $past(in_ksp) && user_stack_pointer == $past(in_usp) && cur_blk == $past(new_blk))
    else $error("swap did not load new context");
  chk_swap_flush: assert property ( // R2
    do_swap && ctrl_asn_off |=> (slot_valid & ~slot_global) == '0)
    else $error("tagless swap kept private entries");
  chk_user_write: assert property ( // R10
    do_lookup && any_hit && !kseg && user && acc == tbf_pkg::ACC_WRITE &&
    !hit_pte[tbf_pkg::PTE_UWE] |=> fault_flag && fault_code == tbf_pkg::FC_ACV)
    else $error("user write without enable not refused");
endmodule

// ===== pkg/tbf_pkg.sv
// Shared constants for the translation buffer and fault unit
package tbf_pkg;
  // ****************************************
  // Buffer geometry and tag codes
  // ****************************************
  localparam int TB_ENTRIES = 8;
  localparam int TAG_BITS = 3;
  localparam int PAGE_BITS = 13;
  localparam int VPN_BITS = 19;
  // Eight tag codes: five process tags, one unused, one global, one invalid
  localparam logic [2:0] ASN_COUNT = 3'h5;
  localparam logic [2:0] TAG_GLOBAL = 3'h6;
  localparam logic [2:0] TAG_INVALID = 3'h7;
  localparam logic [2:0] TAG_DEFAULT = 3'h0;

  // ****************************************
  // Page table entry fields
  // ****************************************
  localparam int PTE_V = 0;
  localparam int PTE_FAULT_READ = 1;
  localparam int PTE_FAULT_WRITE = 2;
  localparam int PTE_FAULT_EXEC = 3;
  localparam int PTE_GLOBAL = 4;
  localparam int PTE_KRE = 8;
  localparam int PTE_URE = 9;
  localparam int PTE_KWE = 12;
  localparam int PTE_UWE = 13;
  localparam int PTE_PFN_LSB = 16;

  // ****************************************
  // Fault codes, access types, modes
  // ****************************************
  localparam logic [2:0] FC_TNV = 3'h0;
  localparam logic [2:0] FC_ACV = 3'h1;
  localparam logic [2:0] FC_FOR = 3'h2;
  localparam logic [2:0] FC_FOE = 3'h3;
  localparam logic [2:0] FC_FOW = 3'h4;
  localparam logic [1:0] ACC_READ = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_EXEC = 2'h2;
  localparam logic MODE_KERNEL = 1'b0;
  localparam logic MODE_USER = 1'b1;
  localparam logic [1:0] KSEG_SEL = 2'h2;

  // ****************************************
  // Commands
  // ****************************************
  localparam logic [3:0] CMD_TBIA = 4'h1;
  localparam logic [3:0] CMD_TBIAP = 4'h2;
  localparam logic [3:0] CMD_TBIS = 4'h3;
  localparam logic [3:0] CMD_LOOKUP = 4'h4;
  localparam logic [3:0] CMD_FILL = 4'h5;
  localparam logic [3:0] CMD_SWAP = 4'h6;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD = 12'h004;
  localparam logic [11:0] REG_VA = 12'h008;
  localparam logic [11:0] REG_ACCESS = 12'h00c;
  localparam logic [11:0] REG_PTE1 = 12'h010;
  localparam logic [11:0] REG_PTE2 = 12'h014;
  localparam logic [11:0] REG_PTE3 = 12'h018;
  localparam logic [11:0] REG_STATUS = 12'h01c;
  localparam logic [11:0] REG_FAULT = 12'h020;
  localparam logic [11:0] REG_PHYS = 12'h024;
  localparam logic [11:0] REG_KSP = 12'h028;
  localparam logic [11:0] REG_USP = 12'h02c;
  localparam logic [11:0] REG_PAGE_TABLE_BASE = 12'h030;
  localparam logic [11:0] REG_ASN = 12'h034;
  localparam logic [11:0] REG_PCC = 12'h038;
  localparam logic [11:0] REG_UNIQUE = 12'h03c;
  localparam logic [11:0] REG_BLOCK = 12'h040;
  localparam logic [2:0] PCB_WIN = 3'h1;

  // ****************************************
  // Context block layout (quadword index = byte offset / 8)
  // ****************************************
  localparam logic [2:0] PCB_KSP = 3'h0;
  localparam logic [2:0] PCB_USP = 3'h1;
  localparam logic [2:0] PCB_PAGE_TABLE_BASE = 3'h2;
  localparam logic [2:0] PCB_ASN = 3'h3;
  localparam logic [2:0] PCB_PCC = 3'h4;
  localparam int PCB_QUADS = 64;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// ===== rtl/tb_slot.sv
// One translation buffer entry with tag match and invalidation
module tb_slot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Maintenance
  input wire logic load,
  input wire logic inv_all,
  input wire logic inv_proc,
  input wire logic inv_one,
  input wire logic [tbf_pkg::VPN_BITS-1:0] fill_vpn,
  input wire logic [2:0] fill_tag,
  input wire logic [31:0] fill_pte,
  // Probe
  input wire logic [2:0] cur_tag,
  input wire logic [tbf_pkg::VPN_BITS-1:0] probe_vpn,
  output logic hit,
  output logic is_valid,
  output logic is_global,
  output logic [31:0] pte
);
  logic [2:0] code;
  logic [tbf_pkg::VPN_BITS-1:0] vpn;

  assign is_valid = code != tbf_pkg::TAG_INVALID;
  assign is_global = code == tbf_pkg::TAG_GLOBAL;
  // Global entries ignore the current tag
  assign hit = is_valid && vpn == probe_vpn && (is_global || code == cur_tag); // R21

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code <= tbf_pkg::TAG_INVALID;
    end else if (load) begin
      code <= fill_tag;
    end else if (inv_all || (inv_proc && !is_global) || (inv_one && hit)) begin
      code <= tbf_pkg::TAG_INVALID; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (load) begin
      vpn <= fill_vpn;
      pte <= fill_pte;
    end
  end
endmodule

// ===== tb/wb_host.sv
// Wishbone master standing in for the pipeline and firmware
module wb_host (
  // Bus
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [11:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Classic single cycle
  // ****
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    dat_w = 32'h0;
  end
  // Request held until ack is sampled; ok stays low if no answer in 64 cycles
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 32'h0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk);
      if (ack === 1'b1) begin
        ok = 1'b1;
        q = dat_r;
      end
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data is inverted so a stale value never looks valid
    dat_w <= ~d;
  endtask
endmodule

// ===== tb/translation_buffer_fault_unit_bench.sv
// Self-checking bench for the translation buffer and fault unit
module translation_buffer_fault_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst_n;
  logic cyc, stb, we, ack;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  int mismatches = 0;
  int total_checks = 0;
  localparam logic [31:0] LEAF = 32'h0012_3301;
  localparam logic [31:0] UPPER = 32'h0000_0101;
  localparam logic [31:0] VA_F = 32'h0000_a000;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  wb_host host (.clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack));
  translation_buffer_fault_unit uut (.REF_CLK(ref_clk), .RST_N(rst_n), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
    .ACK_O(ack));

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    logic [31:0] q;
    logic ok;
    host.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    if (!w) check(q & m, d & m);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 32'hffff_ffff);
  endtask

  task automatic walk(input logic [31:0] va, input logic [31:0] acc, input logic [31:0] p1,
                      input logic [31:0] p3, input logic [3:0] cmd);
    wr(tbf_pkg::REG_VA, va);
    wr(tbf_pkg::REG_ACCESS, acc);
    wr(tbf_pkg::REG_PTE1, p1);
    wr(tbf_pkg::REG_PTE2, UPPER);
    wr(tbf_pkg::REG_PTE3, p3);
    wr(tbf_pkg::REG_CMD, {28'h0, cmd});
  endtask

  // Fill must fault, load nothing and report the code
  task automatic fault_case(input logic [31:0] va, input logic [31:0] acc,
                            input logic [31:0] p1, input logic [31:0] p3, input logic [2:0] c);
    walk(va, acc, p1, p3, tbf_pkg::CMD_FILL);
    bus(1'b0, tbf_pkg::REG_STATUS, 32'h2, 32'h6);
    rd(tbf_pkg::REG_FAULT, {29'h0, c});
  endtask

  task automatic look(input logic [31:0] va, input logic h);
    walk(va, 32'h0, UPPER, LEAF, tbf_pkg::CMD_LOOKUP);
    bus(1'b0, tbf_pkg::REG_STATUS, {31'h0, h}, 32'h1);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic test_reset();
    rd(tbf_pkg::REG_FAULT, 32'h0);
    rd(tbf_pkg::REG_ASN, 32'h0);
    wr(tbf_pkg::REG_STATUS, 32'hf);
    rd(tbf_pkg::REG_STATUS, 32'h0);
    rd(12'h100, 32'h0);
    look(32'h0000_4abc, 1'b0);
    $display("reset test done");
  endtask

  task automatic test_fill();
    walk(32'h0000_4abc, 32'h0, UPPER, LEAF, tbf_pkg::CMD_FILL);
    bus(1'b0, tbf_pkg::REG_STATUS, 32'h4, 32'h6);
    look(32'h0000_4abc, 1'b1);
    rd(tbf_pkg::REG_PHYS, 32'h0002_4abc);
    fault_case(32'h0000_6000, 32'h0, UPPER, 32'h0012_3300, tbf_pkg::FC_TNV);
    look(32'h0000_6000, 1'b0);
    walk(32'h8000_1234, 32'h0, UPPER, LEAF, tbf_pkg::CMD_LOOKUP);
    rd(tbf_pkg::REG_PHYS, 32'h0000_1234);
    $display("fill test done");
  endtask

  task automatic test_faults();
    fault_case(VA_F, 32'h4, UPPER, 32'h0012_3101, tbf_pkg::FC_ACV);
    fault_case(VA_F, 32'h1, UPPER, 32'h0012_2301, tbf_pkg::FC_ACV);
    fault_case(VA_F, 32'h0, 32'h0, LEAF, tbf_pkg::FC_ACV);
    fault_case(VA_F, 32'h0, 32'h100, LEAF, tbf_pkg::FC_TNV);
    fault_case(32'h8000_0000, 32'h4, UPPER, LEAF, tbf_pkg::FC_ACV);
    fault_case(VA_F, 32'h0, UPPER, LEAF | 32'h2, tbf_pkg::FC_FOR);
    fault_case(VA_F, 32'h2, UPPER, LEAF | 32'h8, tbf_pkg::FC_FOE);
    fault_case(VA_F, 32'h1, UPPER, LEAF | 32'h4, tbf_pkg::FC_FOW);
    $display("fault test done");
  endtask

  task automatic test_ctx();
    walk(32'h0000_c000, 32'h0, UPPER, LEAF | 32'h10, tbf_pkg::CMD_FILL);
    wr(tbf_pkg::REG_KSP, 32'h1111);
    wr(tbf_pkg::REG_USP, 32'h2222);
    wr(tbf_pkg::REG_UNIQUE, 32'h3333);
    // Incoming block sits on a 64-byte boundary
    wr(12'h240, 32'haaaa);
    wr(12'h248, 32'hbbbb);
    wr(12'h258, 32'h2);
    wr(tbf_pkg::REG_CMD, 32'h106);
    rd(12'h200, 32'h1111);
    rd(12'h208, 32'h2222);
    rd(12'h224, 32'h3333);
    rd(tbf_pkg::REG_KSP, 32'haaaa);
    rd(tbf_pkg::REG_USP, 32'hbbbb);
    rd(tbf_pkg::REG_ASN, 32'h2);
    rd(tbf_pkg::REG_BLOCK, 32'h1);
    wr(tbf_pkg::REG_USP, 32'h4444);
    rd(tbf_pkg::REG_USP, 32'h4444);
    look(32'h0000_c000, 1'b1);
    look(32'h0000_4abc, 1'b0);
    // Entry changed by firmware is dropped before reuse
    wr(tbf_pkg::REG_VA, 32'h0000_c000);
    wr(tbf_pkg::REG_CMD, {28'h0, tbf_pkg::CMD_TBIS});
    look(32'h0000_c000, 1'b0);
    walk(32'h0000_c000, 32'h0, UPPER, LEAF | 32'h10, tbf_pkg::CMD_FILL);
    walk(32'h0000_e000, 32'h0, UPPER, LEAF, tbf_pkg::CMD_FILL);
    wr(tbf_pkg::REG_CMD, {28'h0, tbf_pkg::CMD_TBIAP});
    look(32'h0000_c000, 1'b1);
    look(32'h0000_e000, 1'b0);
    wr(tbf_pkg::REG_CMD, {28'h0, tbf_pkg::CMD_TBIA});
    look(32'h0000_c000, 1'b0);
    $display("context test done");
  endtask

  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_fill();
    test_faults();
    test_ctx();
    tally_and_finish();
  end
endmodule
